//--- design/ebc_device.sv
// nonvolatile byte store with its I/O access registers and programming engine
// ****************************************************************************
// Summary of operation
// - byte-addressable store of 128, 256 or 512 bytes
// - read strobe stalls processor four cycles
// - program strobe stalls processor two cycles
// - mode 00 armed strobe: erase then write
// - mode 01 armed strobe: erase only
// - mode 10 armed strobe: write only
// - program strobe reads busy until done
// - busy refuses reads, programming, address changes
// - software erases before write-only programming
// - programming timed from calibrated oscillator clock
// - programming survives reset while powered
// - read: wait idle, set address, strobe
// - bit set/clear/test only at 0x00-0x1F
// - I/O at 0x00-0x3F, data space +0x20
// - software writes zero to reserved bits
// - arm bit self-clears after four cycles
// - mode writes ignored while busy
// - atomic 3.4 ms, split 1.8 ms, mode 11 reserved
// - ready interrupt held while idle and enabled (host irq only latches its rising edge in ISTAT, cleared by reading ISTAT)
// ****************************************************************************
//
// Design decisions made here: the register addresses and the APB slave port.
`timescale 1ns/100ps
`include "ebc_params.svh"
module ebc_device #(
	parameter int NV_BYTES   = 512,
	parameter int ATOMIC_CYC = `EBC_T_ATOMIC_US * `EBC_CLK_KHZ / 1000,
	parameter int SPLIT_CYC  = `EBC_T_SPLIT_US * `EBC_CLK_KHZ / 1000
) (
	// clock and resets
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic por_n,
	// processor access path
	ebc_io_if.dev     io
);
	localparam int AW  = $clog2(NV_BYTES);
	localparam int PCW = 17;

	// processor-facing state, cleared by the processor reset
	typedef struct packed {
		logic [AW-1:0] addr;
		logic [7:0]    data;
		logic [1:0]    mode;
		logic          rie;
		logic [2:0]    arm_cnt;
		logic          pend;
		logic [2:0]    stall_cnt;
		logic          ack;
		logic [7:0]    rdata;
	} ebc_dev_s;

	// programming engine, cleared only at power-on
	typedef struct packed {
		logic           busy;
		logic [1:0]     mode;
		logic [AW-1:0]  addr;
		logic [7:0]     data;
		logic [PCW-1:0] cnt;
	} ebc_eng_s;

	ebc_dev_s   c_q;
	ebc_dev_s   c_d;
	ebc_eng_s   e_q;
	ebc_eng_s   e_d;
	logic [7:0] mem [NV_BYTES];
	logic       mem_we;
	logic [7:0] mem_wv;

	// ************************************************************************
	// access decode and register behaviour
	// ************************************************************************
	always_comb begin
		logic [7:0] ioa;
		logic       in_map;
		logic       bit_op;
		logic [7:0] rv;
		logic [7:0] wv;
		logic [7:0] ctrl_rd;
		ioa     = 8'h00;
		in_map  = 1'b0;
		bit_op  = 1'b0;
		rv      = 8'h00;
		wv      = 8'h00;
		c_d     = c_q;
		e_d     = e_q;
		mem_we  = 1'b0;
		mem_wv  = 8'h00;
		c_d.ack = 1'b0;
		ctrl_rd = 8'h00;
		ctrl_rd[`EBC_B_MODE_HI:`EBC_B_MODE_LO] = e_q.busy ? e_q.mode : c_q.mode;
		ctrl_rd[`EBC_B_RIE]  = c_q.rie;
		ctrl_rd[`EBC_B_ARM]  = c_q.arm_cnt != 3'h0;
		ctrl_rd[`EBC_B_PROG] = e_q.busy;
		if (c_q.arm_cnt != 3'h0) begin
			c_d.arm_cnt = c_q.arm_cnt - 3'h1;
		end
		if (c_q.pend) begin
			if (c_q.stall_cnt == 3'h0) begin
				c_d.ack  = 1'b1;
				c_d.pend = 1'b0;
			end else begin
				c_d.stall_cnt = c_q.stall_cnt - 3'h1;
			end
		end
		if (e_q.busy) begin
			if (e_q.cnt == PCW'(1)) begin
				e_d.busy = 1'b0;
				mem_we   = 1'b1;
				unique case (e_q.mode)
					`EBC_MODE_ERASE: mem_wv = `EBC_ERASED_BYTE;
					`EBC_MODE_WRITE: mem_wv = mem[e_q.addr] & e_q.data;
					default:         mem_wv = e_q.data;
				endcase
			end
			e_d.cnt = e_q.cnt - PCW'(1);
		end
		if (io.req && !c_q.pend) begin
			if (io.dspace) begin
				ioa    = io.addr - `EBC_DSPACE_OFS;
				in_map = io.addr >= `EBC_DSPACE_OFS && ioa <= `EBC_IO_TOP;
			end else begin
				ioa    = io.addr;
				in_map = io.addr <= `EBC_IO_TOP;
			end
			bit_op = io.op == ebc_pkg::EBC_OP_SET || io.op == ebc_pkg::EBC_OP_CLR;
			if (in_map) begin
				unique case (ioa)
					`EBC_IO_CTRL:    rv = ctrl_rd;
					`EBC_IO_DATA:    rv = c_q.data;
					`EBC_IO_ADDR_LO: rv = 8'(c_q.addr);
					`EBC_IO_ADDR_HI: rv = 8'({{(16 - AW){1'b0}}, c_q.addr} >> 8);
					default:         rv = 8'h00;
				endcase
			end
			unique case (io.op)
				ebc_pkg::EBC_OP_SET: wv = rv | (8'h01 << io.bit_sel);
				ebc_pkg::EBC_OP_CLR: wv = rv & ~(8'h01 << io.bit_sel);
				default:             wv = io.wdata;
			endcase
			// prog and arm are set by a bit op only when they are its target bit, so a bit op never re-fires them
			if (bit_op && ioa == `EBC_IO_CTRL) begin
				wv[`EBC_B_PROG] = io.op == ebc_pkg::EBC_OP_SET && io.bit_sel == 3'(`EBC_B_PROG);
				wv[`EBC_B_ARM]  = io.op == ebc_pkg::EBC_OP_SET && io.bit_sel == 3'(`EBC_B_ARM);
			end
			c_d.rdata     = rv;
			c_d.pend      = 1'b1;
			c_d.stall_cnt = 3'h0;
			if (in_map && io.op != ebc_pkg::EBC_OP_RD
				&& !(bit_op && ioa > `EBC_IO_BIT_TOP)) begin
				unique case (ioa)
					`EBC_IO_ADDR_LO: begin
						if (!e_q.busy) begin
							c_d.addr = AW'({{(16 - AW){1'b0}}, c_q.addr} & 16'hff00
								| {8'h00, wv});
						end
					end
					`EBC_IO_ADDR_HI: begin
						if (!e_q.busy) begin
							c_d.addr = AW'({{(16 - AW){1'b0}}, c_q.addr} & 16'h00ff
								| {wv, 8'h00});
						end
					end
					`EBC_IO_DATA: c_d.data = wv;
					`EBC_IO_CTRL: begin
						c_d.rie = wv[`EBC_B_RIE];
						if (!e_q.busy) begin
							c_d.mode = wv[`EBC_B_MODE_HI:`EBC_B_MODE_LO];
						end
						if (wv[`EBC_B_ARM] && !wv[`EBC_B_PROG]) begin
							c_d.arm_cnt = `EBC_ARM_CYC;
						end
						if (wv[`EBC_B_READ] && !e_q.busy) begin
							c_d.data      = mem[c_q.addr];
							c_d.stall_cnt = `EBC_READ_STALL;
						end
						if (wv[`EBC_B_PROG] && c_q.arm_cnt != 3'h0 && !e_q.busy
							&& c_d.mode != `EBC_MODE_RSVD) begin
							e_d.busy      = 1'b1;
							e_d.mode      = c_d.mode;
							e_d.addr      = c_q.addr;
							e_d.data      = c_q.data;
							e_d.cnt       = c_d.mode == `EBC_MODE_ATOMIC
								? PCW'(ATOMIC_CYC) : PCW'(SPLIT_CYC);
							c_d.stall_cnt = `EBC_PROG_STALL;
						end
					end
					default: ;
				endcase
			end
		end
	end

	// ************************************************************************
	// state registers
	// ************************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			c_q <= '0;
		end else begin
			c_q <= c_d;
		end
	end

	// engine keeps running through the processor reset
	always_ff @(posedge pclk or negedge por_n) begin
		if (!por_n) begin
			e_q <= '0;
		end else begin
			e_q <= e_d;
		end
	end

	// storage array, no reset: contents are nonvolatile
	always_ff @(posedge pclk) begin
		if (mem_we) begin
			mem[e_q.addr] <= mem_wv;
		end
	end

	// ************************************************************************
	// outputs
	// ************************************************************************
	assign io.rdata     = c_q.rdata;
	assign io.ack       = c_q.ack;
	assign io.stall     = c_q.pend;
	assign io.ready_irq = c_q.rie && !e_q.busy;

endmodule // ebc_device

//--- design/ebc_params.svh
// constants of the byte access controller: offsets, fields, timing
`ifndef EBC_PARAMS_SVH
`define EBC_PARAMS_SVH

// I/O register offsets, as seen by the dedicated I/O instructions
`define EBC_IO_CTRL       8'h1c
`define EBC_IO_DATA       8'h1d
`define EBC_IO_ADDR_LO    8'h1e
`define EBC_IO_ADDR_HI    8'h1f
`define EBC_IO_TOP        8'h3f
`define EBC_IO_BIT_TOP    8'h1f
`define EBC_DSPACE_OFS    8'h20

// control register fields
`define EBC_B_READ        0
`define EBC_B_PROG        1
`define EBC_B_ARM         2
`define EBC_B_RIE         3
`define EBC_B_MODE_LO     4
`define EBC_B_MODE_HI     5

// mode field codes and erased byte value
`define EBC_MODE_ATOMIC   2'h0
`define EBC_MODE_ERASE    2'h1
`define EBC_MODE_WRITE    2'h2
`define EBC_MODE_RSVD     2'h3
`define EBC_ERASED_BYTE   8'hff

// timing
`define EBC_CLK_KHZ       25000
`define EBC_T_ATOMIC_US   3400
`define EBC_T_SPLIT_US    1800
`define EBC_ARM_CYC       3'h4
`define EBC_READ_STALL    3'h4
`define EBC_PROG_STALL    3'h2

// controller register offsets on the APB side
`define EBC_APB_CMD       8'h00
`define EBC_APB_ADDR      8'h04
`define EBC_APB_WDATA     8'h08
`define EBC_APB_RDATA     8'h0c
`define EBC_APB_STATUS    8'h10
`define EBC_APB_ISTAT     8'h14
`define EBC_APB_IMASK     8'h18

// interrupt status bits
`define EBC_I_DONE        0
`define EBC_I_READY       1

`endif

//--- design/ebc_pkg.sv
// types shared by both ends of the byte access controller
package ebc_pkg;
	// kind of I/O access issued by the processor side
	typedef enum logic [1:0] {
		EBC_OP_RD,
		EBC_OP_WR,
		EBC_OP_SET,
		EBC_OP_CLR
	} ebc_op_e;
endpackage

//--- design/ebc_io_if.sv
// I/O access path between the processor side and the storage device
`timescale 1ns/100ps
interface ebc_io_if;
	logic               req;
	ebc_pkg::ebc_op_e   op;
	logic [7:0]         addr;
	logic               dspace;
	logic [2:0]         bit_sel;
	logic [7:0]         wdata;
	logic [7:0]         rdata;
	logic               ack;
	logic               stall;
	logic               ready_irq;

	modport dev (
		input  req, op, addr, dspace, bit_sel, wdata,
		output rdata, ack, stall, ready_irq
	);
	modport cpu (
		output req, op, addr, dspace, bit_sel, wdata,
		input  rdata, ack, stall, ready_irq
	);
endinterface

//--- design/ebc_host.sv
// processor-side end: APB registers that issue I/O accesses to the device
`timescale 1ns/100ps
`include "ebc_params.svh"
module ebc_host (
	// APB slave
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// interrupt
	output logic             irq,
	// device access path
	ebc_io_if.cpu            io
);
	typedef struct packed {
		logic             req;
		ebc_pkg::ebc_op_e op;
		logic             dspace;
		logic [2:0]       bit_sel;
		logic [7:0]       addr;
		logic [7:0]       wdata;
		logic [7:0]       rdata;
		logic             pend;
		logic             rdy_q;
		logic [1:0]       istat;
		logic [1:0]       imask;
		logic [31:0]      prdata;
		logic             slverr;
	} ebc_host_s;

	ebc_host_s h_q;
	ebc_host_s h_d;
	logic      acc;
	logic      cmd_wr;

	// ************************************************************************
	// APB decode and access sequencing
	// ************************************************************************
	assign acc    = psel && penable;
	assign cmd_wr = psel && pwrite && paddr == `EBC_APB_CMD;
	// a command waits while the previous access is outstanding
	assign pready = !(cmd_wr && h_q.pend);

	always_comb begin
		logic [1:0] ev;
		ev         = 2'h0;
		h_d        = h_q;
		h_d.req    = 1'b0;
		h_d.rdy_q  = io.ready_irq;
		if (io.ack) begin
			h_d.pend  = 1'b0;
			h_d.rdata = io.rdata;
			ev[`EBC_I_DONE] = 1'b1;
		end
		ev[`EBC_I_READY] = io.ready_irq && !h_q.rdy_q;
		if (psel && !penable) begin
			h_d.slverr = 1'b0;
			h_d.prdata = 32'h0000_0000;
			unique case (paddr)
				`EBC_APB_CMD:    h_d.prdata = {26'h0, h_q.bit_sel, h_q.dspace, h_q.op};
				`EBC_APB_ADDR:   h_d.prdata = {24'h0, h_q.addr};
				`EBC_APB_WDATA:  h_d.prdata = {24'h0, h_q.wdata};
				`EBC_APB_RDATA:  h_d.prdata = {24'h0, h_q.rdata};
				`EBC_APB_STATUS: h_d.prdata = {30'h0, io.ready_irq, h_q.pend};
				`EBC_APB_ISTAT:  h_d.prdata = {30'h0, h_q.istat};
				`EBC_APB_IMASK:  h_d.prdata = {30'h0, h_q.imask};
				default:         h_d.slverr = 1'b1;
			endcase
		end
		if (acc && pready) begin
			if (pwrite) begin
				unique case (paddr)
					`EBC_APB_CMD: begin
						h_d.op      = ebc_pkg::ebc_op_e'(pwdata[1:0]);
						h_d.dspace  = pwdata[2];
						h_d.bit_sel = pwdata[5:3];
						h_d.req     = 1'b1;
						h_d.pend    = 1'b1;
					end
					`EBC_APB_ADDR:  h_d.addr  = pwdata[7:0];
					`EBC_APB_WDATA: h_d.wdata = pwdata[7:0];
					`EBC_APB_IMASK: h_d.imask = pwdata[1:0];
					default: ;
				endcase
			end else if (paddr == `EBC_APB_ISTAT) begin
				h_d.istat = 2'h0;
			end
		end
		// a new event wins over the clearing read
		h_d.istat = h_d.istat | ev;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			h_q <= '0;
		end else begin
			h_q <= h_d;
		end
	end

	// ************************************************************************
	// outputs
	// ************************************************************************
	assign prdata     = h_q.prdata;
	assign pslverr    = h_q.slverr && acc;
	assign irq        = |(h_q.istat & h_q.imask);
	assign io.req     = h_q.req;
	assign io.op      = h_q.op;
	assign io.addr    = h_q.addr;
	assign io.dspace  = h_q.dspace;
	assign io.bit_sel = h_q.bit_sel;
	assign io.wdata   = h_q.wdata;

endmodule // ebc_host

//--- sim/ebc_sva.sv
// io link checker for the byte access controller
`timescale 1ns/100ps
module ebc_sva (
	// clock and reset
	input logic             pclk,
	input logic             presetn,
	// io link
	input logic             req,
	input ebc_pkg::ebc_op_e op,
	input logic [7:0]       addr,
	input logic             dspace,
	input logic [2:0]       bit_sel,
	input logic [7:0]       wdata,
	input logic [7:0]       rdata,
	input logic             ack,
	input logic             stall,
	input logic             ready_irq
);
	// ****
	// control register writes
	// ****
	logic ctl_wr;
	assign ctl_wr = req && !stall && op == ebc_pkg::EBC_OP_WR && !dspace && addr == 8'h1c;

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	ack_pulse_a: assert property (ack |=> !ack)
		else $error("ack held past one cycle");
	ack_cause_a: assert property (ack |-> $past(req, 2) || $past(req, 4) || $past(req, 6))
		else $error("ack without request at 2, 4 or 6 back");
	ack_due_a: assert property (req && !stall |-> ##[2:6] ack)
		else $error("request not answered in time");
	stall_cap_a: assert property (not (stall [*7]))
		else $error("stall too long");
	stall_src_a: assert property ($rose(stall) |-> $past(req))
		else $error("stall without request");
	stall_end_a: assert property (ack |=> !stall)
		else $error("stall after ack");
	rdata_hold_a: assert property (presetn && $changed(rdata) |-> $rose(stall))
		else $error("rdata moved outside a taken request");
	read_stall_a: assert property (ctl_wr && wdata[0] && !wdata[1] && ready_irq |=> stall [*4])
		else $error("read strobe stall short");
	irq_off_a: assert property (ctl_wr && !wdata[3] |-> ##3 !ready_irq)
		else $error("ready irq with enable clear");

	read_c: cover property (stall [*4]);
	prog_c: cover property (ack && $past(req, 4));
	irq_c: cover property ($rose(ready_irq));
endmodule // ebc_sva

//--- sim/test_eeprom_byte_access_controller.sv
// bench: host and device joined over the io link, driven over APB
`timescale 1ns/100ps
module test_eeprom_byte_access_controller;
	typedef struct {logic [31:0] e; logic [31:0] m; logic s;} ebc_exp_s;
	localparam ebc_pkg::ebc_op_e O_RD = ebc_pkg::EBC_OP_RD;
	localparam ebc_pkg::ebc_op_e O_WR = ebc_pkg::EBC_OP_WR;
	localparam ebc_pkg::ebc_op_e O_SET = ebc_pkg::EBC_OP_SET;
	localparam ebc_pkg::ebc_op_e O_CLR = ebc_pkg::EBC_OP_CLR;
	logic        pclk = 0, presetn = 0, por_n = 0;
	logic        psel = 0, penable = 0, pwrite = 0, hold = 0;
	logic [7:0]  paddr = 0;
	logic [31:0] pwdata = 0;
	logic [31:0] prdata, rd_q;
	logic        pready, pslverr, irq;
	logic [7:0]  v, w;
	int          n_fail = 0, n_compared = 0, seed = 83;
	ebc_exp_s    ex;
	ebc_exp_s    exq[$];

	ebc_io_if io ();
	// busy must outlast the slow APB path so the busy-time writes land inside it
	ebc_device #(.ATOMIC_CYC(200), .SPLIT_CYC(100)) u_ebc_device (.pclk, .presetn, .por_n, .io(io));
	ebc_host u_ebc_host (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
		.prdata, .pready, .pslverr, .irq, .io(io));
	ebc_sva u_ebc_sva (.pclk, .presetn, .req(io.req), .op(io.op), .addr(io.addr),
		.dspace(io.dspace), .bit_sel(io.bit_sel), .wdata(io.wdata), .rdata(io.rdata),
		.ack(io.ack), .stall(io.stall), .ready_irq(io.ready_irq));

	always #20 pclk = ~pclk;

	// ****
	// bus tasks
	// ****
	task automatic cmp(input string nm, input logic [31:0] e, g);
		n_compared++;
		if (g !== e) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic finish_test;
		$display("compared %0d, failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// bb keeps psel up for a setup that follows at once
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic bb);
		if (!hold)
			@(posedge pclk);
		psel <= 1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1);
		rd_q = prdata;
		penable <= 0;
		hold = bb;
		if (!bb)
			psel <= 0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e, m, input logic s = 0);
		exq.push_back(ebc_exp_s'{e, m, s});
		apb(0, a, 0, 0);
	endtask

	task automatic io_op(input ebc_pkg::ebc_op_e o, input logic [7:0] a, d,
		input logic [2:0] b = 0, input logic ds = 0, bb = 0);
		apb(1, 8'h04, a, 0);
		apb(1, 8'h08, d, 0);
		apb(1, 8'h00, {b, ds, o}, bb);
	endtask

	task automatic idle;
		do rd(8'h10, 0, 0); while (rd_q[0]);
	endtask

	task automatic get(input logic [7:0] a, input logic ds = 0);
		io_op(O_RD, a, 0, 0, ds);
		idle;
	endtask

	task automatic nv_wait;
		do begin
			get(8'h1c);
			rd(8'h0c, 0, 0);
		end while (rd_q[1]);
	endtask

	task automatic prog(input logic [1:0] md, input logic [8:0] a, input logic [7:0] d);
		nv_wait;
		io_op(O_WR, 8'h1c, {md, 4'h8});
		io_op(O_WR, 8'h1e, a[7:0]);
		io_op(O_WR, 8'h1f, {7'h0, a[8]});
		io_op(O_WR, 8'h1d, d);
		io_op(O_SET, 8'h1c, 0, 2, 0, 1);
		apb(1, 8'h00, {3'd1, 1'b0, O_SET}, 0);
	endtask

	task automatic nvrd(input logic [8:0] a, input logic [7:0] e);
		nv_wait;
		io_op(O_WR, 8'h1e, a[7:0]);
		io_op(O_WR, 8'h1f, {7'h0, a[8]});
		io_op(O_WR, 8'h1c, 8'h09);
		get(8'h1d);
		rd(8'h0c, e, 8'hff);
	endtask

	// ****
	// scenarios
	// ****
	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1;
		por_n <= 1;
		rd(8'h18, 0, '1);
		rd(8'h10, 0, '1);
		rd(8'h40, 0, '1, 1);
		v = $random(seed);
		prog(0, 9'h1a5, v);
		get(8'h1c);
		rd(8'h0c, 8'h02, 8'h02);
		// address, mode and read strobe while busy
		io_op(O_WR, 8'h1e, 8'h00);
		io_op(O_WR, 8'h1c, 8'h31);
		nv_wait;
		get(8'h1c);
		rd(8'h0c, 0, 8'h33);
		io_op(O_WR, 8'h1d, 8'h00);
		io_op(O_WR, 8'h1c, 8'h01);
		get(8'h1d);
		rd(8'h0c, v, 8'hff);
		prog(1, 9'h1a5, 8'h00);
		nvrd(9'h1a5, 8'hff);
		w = $random(seed);
		prog(2, 9'h1a5, w);
		nvrd(9'h1a5, w);
		prog(3, 9'h1a5, 8'h00);
		nvrd(9'h1a5, w);
		// strobe after the arm window closed
		io_op(O_WR, 8'h1d, ~w);
		io_op(O_SET, 8'h1c, 0, 2);
		idle;
		io_op(O_SET, 8'h1c, 0, 1);
		nvrd(9'h1a5, w);
		io_op(O_WR, 8'h1e, 8'ha5);
		io_op(O_CLR, 8'h1e, 0, 0);
		io_op(O_SET, 8'h1e, 0, 1);
		get(8'h3e, 1);
		rd(8'h0c, 8'ha6, 8'hff);
		apb(1, 8'h18, 3, 0);
		io_op(O_CLR, 8'h1c, 0, 3);
		idle;
		rd(8'h14, 0, 0);
		io_op(O_SET, 8'h1c, 0, 3);
		idle;
		@(negedge pclk);
		cmp("irq", 1, irq);
		rd(8'h10, 2, '1);
		rd(8'h14, 3, '1);
		@(negedge pclk);
		cmp("irq", 0, irq);
		apb(1, 8'h18, 0, 0);
		io_op(O_CLR, 8'h1c, 0, 3);
		io_op(O_SET, 8'h1c, 0, 3);
		idle;
		@(negedge pclk);
		cmp("irq", 0, irq);
		rd(8'h14, 3, '1);
		// processor reset in mid-programming
		prog(0, 9'h0c3, ~v);
		idle;
		@(posedge pclk);
		presetn <= 0;
		@(posedge pclk);
		presetn <= 1;
		nvrd(9'h0c3, ~v);
		finish_test;
	end

	always @(posedge pclk) begin
		if (psel && penable && pready && !pwrite && exq.size() > 0) begin
			ex = exq.pop_front();
			if (ex.m != 0) begin
				cmp("prdata", ex.e, prdata & ex.m);
				cmp("pslverr", ex.s, pslverr);
			end
		end
	end

	initial begin
		repeat (20000) @(posedge pclk);
		n_fail++;
		finish_test;
	end
endmodule // test_eeprom_byte_access_controller
